// ==== rtl/cioc_pkg.sv ====
// Package of constants and types for the camera I/O line conditioning block.
package cioc_pkg;

  // Clock and debounce time base.
  localparam int CLK_PERIOD_PS  = 4000;                          // 250 MHz system clock.
  localparam int DBNC_UNIT_PS   = 1000000;                       // Debounce time unit is 1 us.
  localparam int DBNC_UNIT_CYC  = DBNC_UNIT_PS / CLK_PERIOD_PS;  // Clock cycles per microsecond.
  localparam int DBNC_MAX_US    = 1000000;                       // Longest debounce time, about 1 s.
  localparam int DBNC_W         = 20;                            // Width of a debounce time field.

  // Line indices of the four inputs.
  localparam int LINE_GP  = 0;
  localparam int NUM_IN   = 4;

  // Avalon-MM byte offsets of the registers.
  localparam int          ADDR_W          = 6;
  localparam logic [5:0]  OFS_LINE_MODE   = 6'h00;
  localparam logic [5:0]  OFS_INVERT      = 6'h04;
  localparam logic [5:0]  OFS_GP_SRC      = 6'h08;
  localparam logic [5:0]  OFS_SPARE_SRC   = 6'h0C;
  localparam logic [5:0]  OFS_USER_OUT    = 6'h10;
  localparam logic [5:0]  OFS_TRIG_CFG    = 6'h14;
  localparam logic [5:0]  OFS_TAP_GEOM    = 6'h18;
  localparam logic [5:0]  OFS_LINE_STAT   = 6'h1C;
  localparam logic [5:0]  OFS_DBNC_BASE   = 6'h20;  // Four debounce times: GP, CC1, CC2, CC3.

  // Field positions.
  localparam int INV_OUT_GP     = 4;   // INVERT: bits 3:0 input inverters, 4 and 5 output inverters.
  localparam int INV_OUT_SPARE  = 5;
  localparam int USER_GP_BIT    = 0;   // USER_OUT: GP level in bit 0, spare level in bit 12.
  localparam int USER_SPARE_BIT = 12;
  localparam int TRIG_ACQ_LSB   = 0;   // TRIG_CFG: 5 bits per trigger, enable, activation, source.
  localparam int TRIG_FRM_LSB   = 8;
  localparam int STAT_GP_OUT    = 4;   // LINE_STAT: bits 3:0 conditioned inputs, bit 0 reads zero while GP is an output.
  localparam int STAT_SPARE     = 5;
  localparam int STAT_SPARE_OK  = 6;

  // The CC lines are negative logic: their pin level is flipped before the inverter.
  localparam logic [3:0] IN_NEG_MASK = 4'hE;

  // Output source selection.
  typedef enum logic [2:0] {
    CIOC_SRC_EXPOSURE   = 3'h0,
    CIOC_SRC_FRM_WAIT   = 3'h1,
    CIOC_SRC_USER       = 3'h2,
    CIOC_SRC_ACQ_WAIT   = 3'h3,
    CIOC_SRC_FRM_CYCLE  = 3'h4,
    CIOC_SRC_SYNC_USER  = 3'h5
  } cioc_src_t;

  // Trigger activation.
  typedef enum logic [1:0] {
    CIOC_ACT_RISE  = 2'h0,
    CIOC_ACT_FALL  = 2'h1,
    CIOC_ACT_HIGH  = 2'h2,
    CIOC_ACT_LOW   = 2'h3
  } cioc_act_t;

  // Tap geometry codes that leave no room for the spare bit.
  localparam logic [2:0] TAP_1X8_1Y   = 3'h5;
  localparam logic [2:0] TAP_1X10_1Y  = 3'h6;

  // Reset values.
  localparam logic [2:0] RST_TAP_GEOM = 3'h0;
  localparam cioc_src_t  RST_SRC      = CIOC_SRC_USER;

endpackage

// ==== rtl/cioc_dbnc_if.sv ====
// Interface between the top module and one input debouncer.
`timescale 1ns/1ps
interface cioc_dbnc_if #(
  parameter int DBNC_W = cioc_pkg::DBNC_W
);
  logic              raw;
  logic [DBNC_W-1:0] dly_us;
  logic              level;

  modport ctrl (output raw, output dly_us, input level);
  modport filt (input raw, input dly_us, output level);
endinterface

// ==== rtl/cioc_debounce.sv ====
// One input debouncer with a programmable hold time in microseconds.
`timescale 1ns/1ps
module cioc_debounce #(
  parameter int DBNC_W   = cioc_pkg::DBNC_W,
  parameter int UNIT_CYC = cioc_pkg::DBNC_UNIT_CYC
)(
  input wire logic    sys_clk,
  input wire logic    nrst,
  cioc_dbnc_if.filt   line
);

  localparam int PRE_W = $clog2(UNIT_CYC);
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(UNIT_CYC - 1);

  logic              raw_q;
  logic              lvl_q;
  logic [PRE_W-1:0]  pre_q;
  logic [DBNC_W-1:0] us_q;
  logic              done;

  // Greater-or-equal keeps the filter from hanging when software shortens the time mid-count.
  assign done = (us_q >= line.dly_us);

  // Input sample register; every change against it restarts the count.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      raw_q <= 1'b0;
    end else begin
      raw_q <= line.raw;
    end
  end

  // Per-line microsecond prescaler and hold counter, cleared by every input change.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      pre_q <= '0;
      us_q  <= '0;
    end else if (line.raw != raw_q) begin
      pre_q <= '0; // R19
      us_q  <= '0; // R05
    end else if (!done) begin
      if (pre_q == PRE_LAST) begin
        pre_q <= '0;
        us_q  <= us_q + DBNC_W'(1); // R06
      end else begin
        pre_q <= pre_q + PRE_W'(1);
      end
    end
  end

  // A zero time passes the pin unfiltered; otherwise a level is taken only after its full hold.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      lvl_q <= 1'b0;
    end else if (line.dly_us == '0) begin
      lvl_q <= line.raw; // R07
    end else if (done) begin
      lvl_q <= raw_q; // R05
    end
  end

  assign line.level = lvl_q;

endmodule

// ==== rtl/cioc_top.sv ====
// Camera I/O line conditioning: input debounce, inversion, trigger routing and output sourcing.
//
// Summary of operation
// R01: Matching acquisition source activation raises acquisition trigger.
// R02: Matching frame source activation raises frame trigger.
// R03: Trigger candidates: GP (input only), CC1-CC3.
// R04: Four independent debouncers, each separately timed.
// R05: Pass level only after full hold time.
// R06: Accepted edges delayed by programmed debounce time.
// R07: Time in microseconds, zero passes unfiltered.
// R08: Software picks time above longest glitch.
// R09: Each input has its own polarity inverter.
// R10: Invert bit one inverts, zero passes.
// R11: GP direction selects input or output use.
// R12: Output source picks one of six signals.
// R13: User settable output follows software level.
// R14: Spare bit undriven in two tap geometries.
// R15: Selected output carried on spare data bit.
// R16: Frame grabber extracts spare bit from stream.
// R17: CC inputs negative logic unless inverted.
// R18: User level applied ahead of output inverter.
// R19: Debounce counter restarts on each input change.
`timescale 1ns/1ps
module cioc_top #(
  parameter int DBNC_W   = cioc_pkg::DBNC_W,
  parameter int UNIT_CYC = cioc_pkg::DBNC_UNIT_CYC
)(
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  // Avalon-MM slave.
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // General purpose pin, split into its three signals.
  input  wire logic        gp_pin_in,
  output logic             gp_pin_out,
  output logic             gp_pin_oe_n,
  // Camera control lines from the cable, pin level.
  input  wire logic [2:0]  cc_in,
  // Internal status signals offered as output sources.
  input  wire logic        exposure_active,
  input  wire logic        frame_trig_wait,
  input  wire logic        acq_trig_wait,
  input  wire logic        frame_cycle,
  input  wire logic        sync_user_level,
  // Spare data bit for the link serialiser and its availability.
  output logic             cl_spare_bit,
  output logic             cl_spare_valid,
  // Trigger events towards the acquisition logic.
  output logic             acq_trig,
  output logic             frm_trig
);

  localparam int NUM_IN = cioc_pkg::NUM_IN;

  // Parameters the logic cannot serve are refused at elaboration.
  if (UNIT_CYC < 2 || UNIT_CYC > 4096) begin : g_chk_unit
    $error("UNIT_CYC must lie between 2 and 4096.");
  end
  if (DBNC_W < $clog2(cioc_pkg::DBNC_MAX_US + 1) || DBNC_W > 32) begin : g_chk_w
    $error("DBNC_W cannot hold the longest debounce time.");
  end

  // Software visible control state.
  logic                  line_mode_q;   // One selects output operation of the GP pin.
  logic [NUM_IN-1:0]     in_inv_q;
  logic [1:0]            out_inv_q;     // Bit 0 GP, bit 1 spare.
  cioc_pkg::cioc_src_t   gp_src_q;
  cioc_pkg::cioc_src_t   spare_src_q;
  logic [1:0]            user_out_q;    // Bit 0 GP, bit 1 spare.
  logic [1:0]            trig_en_q;     // Index 0 acquisition, 1 frame.
  cioc_pkg::cioc_act_t   trig_act_q [2];
  logic [1:0]            trig_sel_q [2];
  logic [2:0]            tap_geom_q;
  logic [DBNC_W-1:0]     dbnc_time_q [NUM_IN];

  // Bus handshake state.
  logic                  wait_q;
  logic [31:0]           rdata_q;
  logic                  wr_go;
  logic [31:0]           rd_mux;

  // Datapath state.
  logic [NUM_IN-1:0]     raw_in;
  logic [NUM_IN-1:0]     filt;
  logic [NUM_IN-1:0]     cond;
  logic [NUM_IN-1:0]     cand_ok;
  logic [1:0]            lvl_prev_q;
  logic [1:0]            trig_q;
  logic                  gp_out_q;
  logic                  gp_oe_n_q;
  logic                  spare_q;
  logic                  spare_ok_q;
  logic                  spare_ok;

  // Byte-lane merge of a write into the current register word.
  function automatic logic [31:0] be_merge(input logic [31:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0]  be);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[8*b +: 8] = wd[8*b +: 8];
      end
    end
    return res;
  endfunction

  // Level of the selected output source before the line's inverter.
  function automatic logic src_level(input cioc_pkg::cioc_src_t src, input logic user);
    logic lvl;
    lvl = 1'b0;
    unique case (src)
      cioc_pkg::CIOC_SRC_EXPOSURE:  lvl = exposure_active;
      cioc_pkg::CIOC_SRC_FRM_WAIT:  lvl = frame_trig_wait;
      cioc_pkg::CIOC_SRC_USER:      lvl = user; // R13
      cioc_pkg::CIOC_SRC_ACQ_WAIT:  lvl = acq_trig_wait;
      cioc_pkg::CIOC_SRC_FRM_CYCLE: lvl = frame_cycle;
      cioc_pkg::CIOC_SRC_SYNC_USER: lvl = sync_user_level;
      default:                      lvl = 1'b0;
    endcase
    return lvl;
  endfunction

  // Source codes beyond the six defined ones are not stored; the old selection stays.
  function automatic logic src_legal(input logic [2:0] code);
    return code <= cioc_pkg::CIOC_SRC_SYNC_USER;
  endfunction

  // Every request is held one cycle in waitrequest, then answered; the answer cycle commits a write.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      wait_q <= 1'b1;
    end else if ((avs_read || avs_write) && wait_q) begin
      wait_q <= 1'b0;
    end else begin
      wait_q <= 1'b1;
    end
  end

  assign wr_go = avs_write && !wait_q;

  // Configuration registers.
  always_ff @(posedge sys_clk) begin
    logic [31:0] w;
    w = '0;
    if (!nrst) begin
      line_mode_q <= 1'b0;
      in_inv_q    <= '0;
      out_inv_q   <= '0;
      gp_src_q    <= cioc_pkg::RST_SRC;
      spare_src_q <= cioc_pkg::RST_SRC;
      user_out_q  <= '0;
      trig_en_q   <= '0;
      trig_act_q  <= '{cioc_pkg::CIOC_ACT_RISE, cioc_pkg::CIOC_ACT_RISE};
      trig_sel_q  <= '{2'h0, 2'h0};
      tap_geom_q  <= cioc_pkg::RST_TAP_GEOM;
    end else if (wr_go) begin
      unique case (avs_address)
        cioc_pkg::OFS_LINE_MODE: begin
          w = be_merge({31'h0, line_mode_q}, avs_writedata, avs_byteenable);
          line_mode_q <= w[0]; // R11
        end
        cioc_pkg::OFS_INVERT: begin
          w = be_merge({26'h0, out_inv_q, in_inv_q}, avs_writedata, avs_byteenable);
          in_inv_q  <= w[NUM_IN-1:0]; // R10
          out_inv_q <= w[cioc_pkg::INV_OUT_SPARE:cioc_pkg::INV_OUT_GP];
        end
        cioc_pkg::OFS_GP_SRC: begin
          w = be_merge({29'h0, gp_src_q}, avs_writedata, avs_byteenable);
          if (src_legal(w[2:0])) begin
            gp_src_q <= cioc_pkg::cioc_src_t'(w[2:0]); // R12
          end
        end
        cioc_pkg::OFS_SPARE_SRC: begin
          w = be_merge({29'h0, spare_src_q}, avs_writedata, avs_byteenable);
          if (src_legal(w[2:0])) begin
            spare_src_q <= cioc_pkg::cioc_src_t'(w[2:0]); // R12
          end
        end
        cioc_pkg::OFS_USER_OUT: begin
          w = be_merge({19'h0, user_out_q[1], 11'h0, user_out_q[0]}, avs_writedata, avs_byteenable);
          user_out_q <= {w[cioc_pkg::USER_SPARE_BIT], w[cioc_pkg::USER_GP_BIT]}; // R13
        end
        cioc_pkg::OFS_TRIG_CFG: begin
          w = be_merge({19'h0, trig_en_q[1], trig_act_q[1], trig_sel_q[1],
                        3'h0, trig_en_q[0], trig_act_q[0], trig_sel_q[0]},
                       avs_writedata, avs_byteenable);
          trig_sel_q[0] <= w[cioc_pkg::TRIG_ACQ_LSB +: 2];
          trig_act_q[0] <= cioc_pkg::cioc_act_t'(w[cioc_pkg::TRIG_ACQ_LSB+2 +: 2]);
          trig_en_q[0]  <= w[cioc_pkg::TRIG_ACQ_LSB+4];
          trig_sel_q[1] <= w[cioc_pkg::TRIG_FRM_LSB +: 2];
          trig_act_q[1] <= cioc_pkg::cioc_act_t'(w[cioc_pkg::TRIG_FRM_LSB+2 +: 2]);
          trig_en_q[1]  <= w[cioc_pkg::TRIG_FRM_LSB+4];
        end
        cioc_pkg::OFS_TAP_GEOM: begin
          w = be_merge({29'h0, tap_geom_q}, avs_writedata, avs_byteenable);
          tap_geom_q <= w[2:0];
        end
        default: begin
          w = '0;
        end
      endcase
    end
  end

  // Debounce time registers, one word per input line.
  always_ff @(posedge sys_clk) begin
    logic [31:0] w;
    w = '0;
    if (!nrst) begin
      for (int i = 0; i < NUM_IN; i++) begin
        dbnc_time_q[i] <= '0;
      end
    end else if (wr_go) begin
      for (int i = 0; i < NUM_IN; i++) begin
        if (avs_address == cioc_pkg::OFS_DBNC_BASE + 6'(4 * i)) begin
          w = be_merge(32'(dbnc_time_q[i]), avs_writedata, avs_byteenable);
          dbnc_time_q[i] <= w[DBNC_W-1:0]; // R04
        end
      end
    end
  end

  // Read multiplexer; unmapped addresses read as zero.
  always_comb begin
    rd_mux = '0;
    unique case (avs_address)
      cioc_pkg::OFS_LINE_MODE: rd_mux = {31'h0, line_mode_q};
      cioc_pkg::OFS_INVERT:    rd_mux = {26'h0, out_inv_q, in_inv_q};
      cioc_pkg::OFS_GP_SRC:    rd_mux = {29'h0, gp_src_q};
      cioc_pkg::OFS_SPARE_SRC: rd_mux = {29'h0, spare_src_q};
      cioc_pkg::OFS_USER_OUT:  rd_mux = {19'h0, user_out_q[1], 11'h0, user_out_q[0]};
      cioc_pkg::OFS_TRIG_CFG:  rd_mux = {19'h0, trig_en_q[1], trig_act_q[1], trig_sel_q[1],
                                         3'h0, trig_en_q[0], trig_act_q[0], trig_sel_q[0]};
      cioc_pkg::OFS_TAP_GEOM:  rd_mux = {29'h0, tap_geom_q};
      cioc_pkg::OFS_LINE_STAT: rd_mux = {25'h0, spare_ok_q, spare_q, gp_out_q, cond & cand_ok};
      default: begin
        for (int i = 0; i < NUM_IN; i++) begin
          if (avs_address == cioc_pkg::OFS_DBNC_BASE + 6'(4 * i)) begin
            rd_mux = 32'(dbnc_time_q[i]);
          end
        end
      end
    endcase
  end

  // Read data are captured on the first request cycle and stand through the answer cycle.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      rdata_q <= '0;
    end else if (avs_read && wait_q) begin
      rdata_q <= rd_mux;
    end
  end

  assign avs_readdata    = rdata_q;
  assign avs_waitrequest = wait_q;

  // Pin levels into the debouncers: GP in bit 0, CC1 to CC3 above it.
  assign raw_in = {cc_in, gp_pin_in};

  // One independent debouncer per input line.
  for (genvar i = 0; i < NUM_IN; i++) begin : g_dbnc
    cioc_dbnc_if #(.DBNC_W(DBNC_W)) dbnc_if ();
    assign dbnc_if.raw    = raw_in[i];
    assign dbnc_if.dly_us = dbnc_time_q[i];
    assign filt[i]        = dbnc_if.level;
    cioc_debounce #(
      .DBNC_W   (DBNC_W),
      .UNIT_CYC (UNIT_CYC)
    ) u_dbnc (
      .sys_clk (sys_clk),
      .nrst    (nrst),
      .line    (dbnc_if)
    ); // R04
  end

  // Inversion follows the debouncer; the CC lines carry a fixed extra flip for negative logic.
  assign cond = filt ^ cioc_pkg::IN_NEG_MASK ^ in_inv_q; // R09 R17

  // The GP line is a trigger candidate only while it is an input.
  assign cand_ok = {3'b111, ~line_mode_q}; // R03 R11

  // Trigger routing and activation matching for acquisition start and frame start.
  always_ff @(posedge sys_clk) begin
    logic lvl;
    logic ok;
    lvl = 1'b0;
    ok  = 1'b0;
    if (!nrst) begin
      lvl_prev_q <= '0;
      trig_q     <= '0;
    end else begin
      for (int t = 0; t < 2; t++) begin
        lvl = cond[trig_sel_q[t]];               // R03
        ok  = trig_en_q[t] && cand_ok[trig_sel_q[t]];
        lvl_prev_q[t] <= lvl;
        unique case (trig_act_q[t])
          cioc_pkg::CIOC_ACT_RISE: trig_q[t] <= ok && lvl && !lvl_prev_q[t]; // R01 R02
          cioc_pkg::CIOC_ACT_FALL: trig_q[t] <= ok && !lvl && lvl_prev_q[t]; // R01 R02
          cioc_pkg::CIOC_ACT_HIGH: trig_q[t] <= ok && lvl;                   // R01 R02
          cioc_pkg::CIOC_ACT_LOW:  trig_q[t] <= ok && !lvl;                  // R01 R02
        endcase
      end
    end
  end

  assign acq_trig = trig_q[0];
  assign frm_trig = trig_q[1];

  // The spare bit has no slot in the two tap geometries 1X8-1Y and 1X10-1Y.
  assign spare_ok = (tap_geom_q != cioc_pkg::TAP_1X8_1Y) && (tap_geom_q != cioc_pkg::TAP_1X10_1Y); // R14

  // Output lines: source, then inverter, then register; the pin is released while it is an input.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      gp_out_q   <= 1'b0;
      gp_oe_n_q  <= 1'b1;
      spare_q    <= 1'b0;
      spare_ok_q <= 1'b0;
    end else begin
      gp_oe_n_q  <= ~line_mode_q; // R11
      gp_out_q   <= line_mode_q & (src_level(gp_src_q, user_out_q[0]) ^ out_inv_q[0]); // R18
      spare_ok_q <= spare_ok; // R14
      spare_q    <= spare_ok & (src_level(spare_src_q, user_out_q[1]) ^ out_inv_q[1]); // R15 R18
    end
  end

  assign gp_pin_out     = gp_out_q;
  assign gp_pin_oe_n    = gp_oe_n_q;
  assign cl_spare_bit   = spare_q;
  assign cl_spare_valid = spare_ok_q;

endmodule

// ==== bench/cioc_top_sva.sv ====
// Concurrent checks on the ports of the line conditioning block.
`timescale 1ns/1ps
module cioc_top_sva #(
  parameter int DBNC_W   = 20,
  parameter int UNIT_CYC = 250
)(
  input wire logic        sys_clk,
  input wire logic        nrst,
  input wire logic [5:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        gp_pin_out,
  input wire logic        gp_pin_oe_n,
  input wire logic        exposure_active,
  input wire logic        frame_trig_wait,
  input wire logic        acq_trig_wait,
  input wire logic        frame_cycle,
  input wire logic        sync_user_level,
  input wire logic        cl_spare_bit,
  input wire logic        cl_spare_valid
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  logic [4:0] src_q;
  logic       src_chg;
  logic       wr_done;

  // An output may only move after a status input or a register write moved first.
  always_ff @(posedge sys_clk) begin
    src_q <= {sync_user_level, frame_cycle, acq_trig_wait, frame_trig_wait, exposure_active};
  end
  assign src_chg = src_q != {sync_user_level, frame_cycle, acq_trig_wait, frame_trig_wait, exposure_active};
  assign wr_done = avs_write && !avs_waitrequest;

  sequence s_take;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_stat_rd;
    s_take ##0 avs_read && (avs_address == cioc_pkg::OFS_LINE_STAT);
  endsequence

  chk_req_answer: assert property (s_take |=> !avs_waitrequest)
    else $error("request not answered after one wait cycle");
  chk_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  chk_idle_wait: assert property (!avs_read && !avs_write && avs_waitrequest |=> avs_waitrequest)
    else $error("answer without a request");
  chk_unmapped_zero: assert property (s_take ##0 avs_read && avs_address >= 6'h30 |=> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  chk_stat_echo: assert property (s_stat_rd |=> avs_readdata[6:4] ==
    {$past(cl_spare_valid), $past(cl_spare_bit), $past(gp_pin_out)})
    else $error("status read disagrees with pins");
  chk_spare_off: assert property (!cl_spare_valid |-> !cl_spare_bit)
    else $error("spare bit driven while unavailable");
  chk_gp_input_low: assert property (gp_pin_oe_n |-> !gp_pin_out)
    else $error("drive level high in input mode");
  // A write moves an output one edge after its commit edge, so the check sees it two samples after the write.
  chk_spare_cause: assert property ($changed(cl_spare_bit) && cl_spare_valid && $past(cl_spare_valid)
    |-> $past(src_chg) || $past(wr_done, 2))
    else $error("spare bit changed without cause");
  chk_gp_cause: assert property ($changed(gp_pin_out) && !gp_pin_oe_n && !$past(gp_pin_oe_n)
    |-> $past(src_chg) || $past(wr_done, 2))
    else $error("gp output changed without cause");
endmodule

bind cioc_top cioc_top_sva #(.DBNC_W(DBNC_W), .UNIT_CYC(UNIT_CYC)) i_sva (
  .sys_clk(sys_clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .gp_pin_out(gp_pin_out), .gp_pin_oe_n(gp_pin_oe_n), .exposure_active(exposure_active),
  .frame_trig_wait(frame_trig_wait), .acq_trig_wait(acq_trig_wait), .frame_cycle(frame_cycle),
  .sync_user_level(sync_user_level), .cl_spare_bit(cl_spare_bit), .cl_spare_valid(cl_spare_valid));

// ==== bench/cioc_fg_model.sv ====
// Frame grabber model: drives the camera control lines and extracts the spare bit.
`timescale 1ns/1ps
module cioc_fg_model (
  input  wire logic       sys_clk,
  output logic      [2:0] cc_in,
  input  wire logic       cl_spare_bit,
  input  wire logic       cl_spare_valid,
  output logic            spare_seen
);
  // The control lines idle low until a scenario drives them.
  initial cc_in = 3'h0;

  // Outside the geometries that carry it, the stream holds no spare bit, so nothing is read.
  assign spare_seen = cl_spare_valid & cl_spare_bit;

  // Level changes happen just after an edge, like a real synchronous transmitter.
  task automatic drive(input int idx, input logic lvl);
    @(posedge sys_clk);
    cc_in[idx] <= lvl;
  endtask
endmodule

// ==== bench/tb_camera_io_line_conditioning.sv ====
// Self-checking testbench for the line conditioning block.
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin miscompares++; \
  $display("unexpected at %0t: got %0h expected %0h", $time, (a), (b)); end end
module tb_camera_io_line_conditioning;
  localparam int UNIT = 4;
  logic        sys_clk = 1'b0;
  logic        nrst = 1'b0;
  logic [5:0]  avs_address = 6'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        gp_drv = 1'b0;
  logic        gp_pin_in;
  logic        gp_pin_out;
  logic        gp_pin_oe_n;
  logic [2:0]  cc_in;
  logic [5:0]  src_v = 6'h00;
  logic        cl_spare_bit;
  logic        cl_spare_valid;
  logic        spare_seen;
  logic        acq_trig;
  logic        frm_trig;
  int          miscompares = 0;
  int          compares = 0;

  // Half period of 2 ns gives the 250 MHz system clock.
  always #2 sys_clk = ~sys_clk;
  // The pin shows the block's drive while enabled, otherwise the outside driver.
  assign gp_pin_in = gp_pin_oe_n ? gp_drv : gp_pin_out;

  cioc_top #(.UNIT_CYC(UNIT)) i_dut (
    .sys_clk(sys_clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .gp_pin_in(gp_pin_in),
    .gp_pin_out(gp_pin_out), .gp_pin_oe_n(gp_pin_oe_n), .cc_in(cc_in),
    .exposure_active(src_v[0]), .frame_trig_wait(src_v[1]), .acq_trig_wait(src_v[3]),
    .frame_cycle(src_v[4]), .sync_user_level(src_v[5]), .cl_spare_bit(cl_spare_bit),
    .cl_spare_valid(cl_spare_valid), .acq_trig(acq_trig), .frm_trig(frm_trig));

  cioc_fg_model i_fg (
    .sys_clk(sys_clk), .cc_in(cc_in), .cl_spare_bit(cl_spare_bit),
    .cl_spare_valid(cl_spare_valid), .spare_seen(spare_seen));

  task automatic finish_test;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // One bus access; the request is held until waitrequest is seen low, and only the watchdog ends a hang.
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    do begin
      @(posedge sys_clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [5:0] a, output logic [31:0] q);
    bus(1'b0, a, 32'h0, q);
  endtask

  // Counts acquisition trigger pulses and the cycle of the first one.
  task automatic watch_acq(input int n, output int cnt, output int first);
    cnt = 0;
    first = -1;
    for (int i = 0; i < n; i++) begin
      @(posedge sys_clk);
      if (acq_trig === 1'b1) begin
        cnt++;
        if (first < 0) first = i;
      end
    end
  endtask

  // Status bits after reset, negative control lines and the input inverters.
  task automatic test_regs;
    logic [31:0] q;
    rd(cioc_pkg::OFS_LINE_STAT, q);
    `CHK(q, 32'h0000004E)
    i_fg.drive(0, 1'b1);
    repeat (4) @(posedge sys_clk);
    rd(cioc_pkg::OFS_LINE_STAT, q);
    `CHK(q, 32'h0000004C)
    wr(cioc_pkg::OFS_INVERT, 32'h2);
    repeat (3) @(posedge sys_clk);
    rd(cioc_pkg::OFS_LINE_STAT, q);
    `CHK(q, 32'h0000004E)
    i_fg.drive(0, 1'b0);
    wr(6'h30, 32'hFFFFFFFF);
    rd(6'h30, q);
    `CHK(q, 32'h0)
    rd(cioc_pkg::OFS_TAP_GEOM, q);
    `CHK(q[2:0], 3'h0)
  endtask

  // Every spare source code, a refused code and the two geometries without room.
  task automatic test_spare;
    for (int k = 0; k < 6; k++) begin
      wr(cioc_pkg::OFS_SPARE_SRC, k);
      src_v <= 6'h01 << k;
      wr(cioc_pkg::OFS_USER_OUT, (k == 2) ? 32'h1000 : 32'h0);
      repeat (3) @(posedge sys_clk);
      `CHK(spare_seen, 1'b1)
      src_v <= 6'h00;
      wr(cioc_pkg::OFS_USER_OUT, 32'h0);
      repeat (3) @(posedge sys_clk);
      `CHK(spare_seen, 1'b0)
    end
    wr(cioc_pkg::OFS_SPARE_SRC, 32'h0);
    wr(cioc_pkg::OFS_SPARE_SRC, 32'h7);
    src_v <= 6'h01;
    repeat (3) @(posedge sys_clk);
    `CHK(cl_spare_bit, 1'b1)
    for (int g = 5; g < 7; g++) begin
      wr(cioc_pkg::OFS_TAP_GEOM, g);
      repeat (3) @(posedge sys_clk);
      `CHK({cl_spare_valid, cl_spare_bit}, 2'b00)
    end
    wr(cioc_pkg::OFS_TAP_GEOM, 32'h0);
    repeat (3) @(posedge sys_clk);
    `CHK({cl_spare_valid, cl_spare_bit}, 2'b11)
    src_v <= 6'h00;
  endtask

  // A short glitch on a debounced line is dropped; a held level fires once, late.
  task automatic test_debounce;
    int cnt, first;
    wr(cioc_pkg::OFS_INVERT, 32'h2);
    wr(cioc_pkg::OFS_DBNC_BASE + 6'h04, 32'h2);
    wr(cioc_pkg::OFS_TRIG_CFG, 32'h11);
    repeat (20) @(posedge sys_clk);
    fork
      watch_acq(60, cnt, first);
      begin
        i_fg.drive(0, 1'b1);
        repeat (4) @(posedge sys_clk);
        i_fg.drive(0, 1'b0);
      end
    join
    `CHK(cnt, 0)
    fork
      watch_acq(60, cnt, first);
      i_fg.drive(0, 1'b1);
    join
    `CHK(cnt, 1)
    `CHK(first >= 2 * UNIT && first <= 2 * UNIT + 8, 1'b1)
    wr(cioc_pkg::OFS_TRIG_CFG, 32'h15);
    fork
      watch_acq(60, cnt, first);
      i_fg.drive(0, 1'b0);
    join
    `CHK(cnt, 1)
  endtask

  // Level frame trigger from the unfiltered pin, then the pin turned into an output.
  task automatic test_gp;
    wr(cioc_pkg::OFS_TRIG_CFG, 32'h1800);
    gp_drv <= 1'b1;
    repeat (5) @(posedge sys_clk);
    `CHK(frm_trig, 1'b1)
    gp_drv <= 1'b0;
    repeat (5) @(posedge sys_clk);
    `CHK(frm_trig, 1'b0)
    wr(cioc_pkg::OFS_GP_SRC, 32'h2);
    wr(cioc_pkg::OFS_USER_OUT, 32'h1);
    wr(cioc_pkg::OFS_LINE_MODE, 32'h1);
    repeat (5) @(posedge sys_clk);
    `CHK({gp_pin_oe_n, gp_pin_out, frm_trig}, 3'b010)
    wr(cioc_pkg::OFS_INVERT, 32'h12);
    repeat (3) @(posedge sys_clk);
    `CHK(gp_pin_out, 1'b0)
    wr(cioc_pkg::OFS_LINE_MODE, 32'h0);
    repeat (3) @(posedge sys_clk);
    `CHK({gp_pin_oe_n, gp_pin_out}, 2'b10)
  endtask

  // Main sequence: reset for 12 cycles, then each scenario in turn.
  initial begin
    repeat (12) @(posedge sys_clk);
    nrst <= 1'b1;
    @(posedge sys_clk);
    test_regs();
    test_spare();
    test_debounce();
    test_gp();
    finish_test();
  end

  // The run needs a few hundred cycles; a much longer wait means a hang.
  initial begin
    #100000;
    miscompares++;
    finish_test();
  end
endmodule
